// ### core/ltsb_pkg.sv
// constants, enums and carrier structs for the lamp and touch switch bit engine
// assumes one 10 MHz clock shared by the register bus and the controller link logic
package ltsb_pkg;

  // sizes
  localparam int NUM_LAMP = 4;
  localparam int NUM_SW   = 4;
  localparam int AXI_AW   = 8;
  localparam int IRQ_W    = NUM_SW + 2;

  // register byte offsets
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_DISP      = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT  = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK  = 8'h0C;
  localparam logic [3:0] BLK_LAMP      = 4'h1;
  localparam logic [3:0] BLK_NTF       = 4'h2;
  localparam logic [3:0] BLK_CTL       = 4'h3;

  // address groups returned by the decoder
  localparam logic [2:0] GRP_CTRL  = 3'h0;
  localparam logic [2:0] GRP_DISP  = 3'h1;
  localparam logic [2:0] GRP_IRQS  = 3'h2;
  localparam logic [2:0] GRP_IRQM  = 3'h3;
  localparam logic [2:0] GRP_LAMP  = 3'h4;
  localparam logic [2:0] GRP_NTF   = 3'h5;
  localparam logic [2:0] GRP_CTL   = 3'h6;
  localparam logic [2:0] GRP_NONE  = 3'h7;

  // control register fields
  localparam int CTRL_FAST_LINK = 0;
  localparam int CTRL_REV2      = 1;
  localparam int CTRL_POLL_EN   = 2;
  localparam int CTRL_SCREEN    = 3;
  localparam logic [2:0] CTRL_RST = 3'h0;

  // item configuration word: bits 26..0 map onto ltsb_cfg_s
  localparam int CFG_W = 27;
  localparam logic [31:0] CFG_MASK = 32'h07FFFFFF;
  localparam logic [31:0] CFG_RST  = 32'h00000000;

  // irq status layout: notify done per switch, then copy done, then poll done
  localparam int IRQ_COPY = NUM_SW;
  localparam int IRQ_POLL = NUM_SW + 1;
  localparam logic [IRQ_W-1:0] IRQ_RST = 6'h00;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // refresh period of lamp and control bits
  localparam int CLK_PERIOD_NS  = 100;
  localparam int POLL_PERIOD_US = 10000;
  localparam int POLL_CYCLES    = POLL_PERIOD_US * 1000 / CLK_PERIOD_NS;

  localparam logic [15:0] WORD_ALL = 16'hFFFF;
  localparam logic [15:0] BIT_ONE  = 16'h0001;

  typedef enum logic [2:0] {
    AREA_DATA_MEMORY, AREA_INTERNAL_RELAY, AREA_HOLDING_RELAY, AREA_AUXILIARY_RELAY,
    AREA_LINK_RELAY, AREA_TIMER, AREA_COUNTER
  } ltsb_area_e;

  typedef enum logic [1:0] {MODE_MOMENTARY, MODE_ALTERNATE, MODE_SET, MODE_RESET} ltsb_mode_e;

  typedef enum logic [1:0] {JOB_NOTIFY, JOB_COPY, JOB_POLL} ltsb_job_e;

  typedef enum logic {ST_IDLE, ST_WAIT} ltsb_state_e;

  typedef struct packed {
    logic       en;
    logic       flash;
    ltsb_mode_e mode;
    ltsb_area_e area;
    logic [3:0] bitpos;
    logic [15:0] word;
  } ltsb_cfg_s;

  typedef struct packed {
    logic        write;
    ltsb_area_e  area;
    logic [15:0] word;
    logic [15:0] wdata;
    logic [15:0] wmask;
  } ltsb_lk_req_s;

endpackage

// ### core/ltsb_engine.sv
// lamp and touch switch bit engine: axi4-lite registers, controller word link, display state
// assumes the controller memory logic runs on aclk and answers each link request with one ack pulse
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module ltsb_engine
  import ltsb_pkg::*;
#(
  parameter int unsigned POLL_CYC = POLL_CYCLES
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [AXI_AW-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output wire logic               s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output wire logic               s_axi_wready,
  output wire logic [1:0]         s_axi_bresp,
  output wire logic               s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [AXI_AW-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output wire logic               s_axi_arready,
  output wire logic [31:0]        s_axi_rdata,
  output wire logic [1:0]         s_axi_rresp,
  output wire logic               s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic [NUM_SW-1:0]  touch_press,
  output wire ltsb_lk_req_s       lk_req,
  output wire logic               lk_req_valid,
  input  wire logic               lk_ack,
  input  wire logic [15:0]        lk_rdata,
  output wire logic [NUM_LAMP-1:0] lamp_lit,
  output wire logic [NUM_LAMP-1:0] lamp_flash,
  output wire logic [NUM_SW-1:0]  sw_lit,
  output wire logic [NUM_SW-1:0]  sw_flash,
  output wire logic               irq
);

  // helpers shared by the decoders and the sequencer
  function automatic logic [2:0] addr_grp(input logic [AXI_AW-1:0] a);
    logic [2:0] g;
    g = GRP_NONE;
    if (a == REG_CTRL) g = GRP_CTRL;
    else if (a == REG_DISP) g = GRP_DISP;
    else if (a == REG_IRQ_STAT) g = GRP_IRQS;
    else if (a == REG_IRQ_MASK) g = GRP_IRQM;
    else if (a[7:4] == BLK_LAMP && a[1:0] == 2'h0) g = GRP_LAMP;
    else if (a[7:4] == BLK_NTF && a[1:0] == 2'h0) g = GRP_NTF;
    else if (a[7:4] == BLK_CTL && a[1:0] == 2'h0) g = GRP_CTL;
    return g;
  endfunction

  function automatic ltsb_cfg_s cfg_of(input logic [31:0] r);
    return ltsb_cfg_s'(r[CFG_W-1:0]);
  endfunction

  function automatic logic item_ok(input ltsb_cfg_s c);
    return c.en && c.area != AREA_TIMER && c.area != AREA_COUNTER;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return ((old & ~m) | (nw & m)) & CFG_MASK;
  endfunction

  function automatic logic [1:0] first_set(input logic [NUM_SW-1:0] v);
    logic [1:0] k;
    k = 2'h0;
    for (int j = NUM_SW - 1; j >= 0; j--) begin
      if (v[j]) k = 2'(j);
    end
    return k;
  endfunction

  // register and state storage
  logic [31:0]       lamp_cfg_r [NUM_LAMP];
  logic [31:0]       ntf_cfg_r  [NUM_SW];
  logic [31:0]       ctl_cfg_r  [NUM_SW];
  logic [15:0]       copy_word_r [NUM_SW];
  logic [2:0]        ctrl_r;
  logic [IRQ_W-1:0]  irq_stat_r, irq_mask_r, irq_ev;
  logic              irq_r;
  logic              aw_have_r, w_have_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [AXI_AW-1:0] aw_addr_r;
  logic [31:0]       w_data_r, rdata_r, rd_val;
  logic [3:0]        w_strb_r;
  logic [1:0]        bresp_r, rresp_r;
  logic [NUM_SW-1:0] s1_r, s2_r, s3_r, prs_r, cur_r, cur_nxt, pend_r, pend_nxt, ign_r, ign_nxt;
  logic [NUM_LAMP-1:0] lamp_on_r, lamp_lit_r, lamp_flash_r, lamp_on_nxt;
  logic [NUM_SW-1:0] ctl_on_r, sw_lit_r, sw_flash_r, ctl_on_nxt, issue_clr;
  ltsb_state_e       st_r, st_nxt;
  ltsb_job_e         job_r, job_nxt;
  logic [2:0]        job_idx_r, job_idx_nxt, scan_r, scan_nxt;
  logic [1:0]        copy_idx_r, copy_idx_nxt;
  logic              copy_pend_r, copy_pend_nxt, poll_act_r, poll_act_nxt;
  logic [31:0]       poll_cnt_r;
  ltsb_lk_req_s      lk_req_r, lk_req_nxt;
  logic              lk_valid_r, lk_valid_nxt;

  // bus decode
  wire logic       aw_take  = s_axi_awvalid & awready_r;
  wire logic       w_take   = s_axi_wvalid & wready_r;
  wire logic       wr_do    = aw_have_r & w_have_r & ~bvalid_r;
  wire logic [2:0] wr_grp   = addr_grp(aw_addr_r);
  wire logic [1:0] wr_idx   = aw_addr_r[3:2];
  wire logic       ar_take  = s_axi_arvalid & arready_r;
  wire logic [2:0] rd_grp   = addr_grp(s_axi_araddr);
  wire logic [1:0] rd_idx   = s_axi_araddr[3:2];
  wire logic       scr_pulse = wr_do && wr_grp == GRP_CTRL && w_strb_r[0] && w_data_r[CTRL_SCREEN];
  wire logic       irqs_rd  = ar_take && rd_grp == GRP_IRQS;
  wire logic       fast_link = ctrl_r[CTRL_FAST_LINK];
  wire logic       rev2      = ctrl_r[CTRL_REV2];

  // press sync: a level counts once the second and third stages agree
  wire logic [NUM_SW-1:0] agree = ~(s2_r ^ s3_r);
  wire logic [NUM_SW-1:0] rise  = agree & s3_r & ~prs_r;
  wire logic [NUM_SW-1:0] fall  = agree & ~s3_r & prs_r;

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign lk_req        = lk_req_r;
  assign lk_req_valid  = lk_valid_r;
  assign lamp_lit      = lamp_lit_r;
  assign lamp_flash    = lamp_flash_r;
  assign sw_lit        = sw_lit_r;
  assign sw_flash      = sw_flash_r;
  assign irq           = irq_r;

  // read data mux
  always_comb begin
    rd_val = 32'h00000000;
    case (rd_grp)
      GRP_CTRL: rd_val = {29'h0, ctrl_r};
      GRP_DISP: rd_val = {10'h0, poll_act_r, copy_pend_r, pend_r, sw_flash_r, sw_lit_r, lamp_flash_r, lamp_lit_r};
      GRP_IRQS: rd_val = {26'h0, irq_stat_r};
      GRP_IRQM: rd_val = {26'h0, irq_mask_r};
      GRP_LAMP: rd_val = lamp_cfg_r[rd_idx];
      GRP_NTF:  rd_val = ntf_cfg_r[rd_idx];
      GRP_CTL:  rd_val = ctl_cfg_r[rd_idx];
      default:  rd_val = 32'h00000000;
    endcase
  end

  // axi4-lite handshakes; one write and one read in flight, address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h00000000;
      w_strb_r  <= 4'h0;
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_have_r <= 1'b1;
        awready_r <= 1'b0;
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_r <= 1'b1;
        wready_r <= 1'b0;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_do) begin
        bvalid_r <= 1'b1;
        bresp_r  <= (wr_grp == GRP_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r  <= 1'b0;
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
      if (ar_take) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rdata_r   <= rd_val;
        rresp_r   <= (rd_grp == GRP_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // register writes; the screen bit is a write-one pulse and is not stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r     <= CTRL_RST;
      irq_mask_r <= IRQ_RST;
      for (int i = 0; i < NUM_LAMP; i++) lamp_cfg_r[i] <= CFG_RST;
      for (int i = 0; i < NUM_SW; i++) begin
        ntf_cfg_r[i] <= CFG_RST;
        ctl_cfg_r[i] <= CFG_RST;
      end
    end else if (wr_do) begin
      if (wr_grp == GRP_CTRL && w_strb_r[0]) ctrl_r <= w_data_r[2:0];
      if (wr_grp == GRP_IRQM && w_strb_r[0]) irq_mask_r <= w_data_r[IRQ_W-1:0];
      if (wr_grp == GRP_LAMP) lamp_cfg_r[wr_idx] <= merge(lamp_cfg_r[wr_idx], w_data_r, w_strb_r);
      if (wr_grp == GRP_NTF) ntf_cfg_r[wr_idx] <= merge(ntf_cfg_r[wr_idx], w_data_r, w_strb_r);
      if (wr_grp == GRP_CTL) ctl_cfg_r[wr_idx] <= merge(ctl_cfg_r[wr_idx], w_data_r, w_strb_r);
    end
  end

  // sticky irq bits: a read clears, an event in the same cycle still sets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= IRQ_RST;
      irq_r      <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~(irqs_rd ? irq_stat_r : IRQ_RST)) | irq_ev;
      irq_r      <= |(irq_stat_r & irq_mask_r);
    end
  end

  // touch press synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      prs_r <= '0;
    end else begin
      s1_r  <= touch_press;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      prs_r <= (agree & s3_r) | (~agree & prs_r);
    end
  end

  // notify bit decisions per switch; the bit value is what gets written next
  always_comb begin
    ltsb_cfg_s  c;
    ltsb_mode_e md;
    c        = cfg_of(32'h0);
    md       = MODE_MOMENTARY;
    cur_nxt  = cur_r;
    pend_nxt = pend_r & ~issue_clr;
    ign_nxt  = ign_r & ~fall;
    for (int i = 0; i < NUM_SW; i++) begin
      c  = cfg_of(ntf_cfg_r[i]);
      md = rev2 ? c.mode : MODE_MOMENTARY;
      if (item_ok(c)) begin
        if (scr_pulse && md == MODE_MOMENTARY && prs_r[i] && !ign_r[i]) begin
          cur_nxt[i]  = 1'b0;
          pend_nxt[i] = 1'b1;
          ign_nxt[i]  = 1'b1;
        end else if (rise[i]) begin
          pend_nxt[i] = 1'b1;
          case (md)
            MODE_MOMENTARY: cur_nxt[i] = 1'b1;
            MODE_ALTERNATE: cur_nxt[i] = ~cur_r[i];
            MODE_SET:       cur_nxt[i] = 1'b1;
            MODE_RESET:     cur_nxt[i] = 1'b0;
            default:        cur_nxt[i] = cur_r[i];
          endcase
        end else if (fall[i] && md == MODE_MOMENTARY && !ign_r[i]) begin
          cur_nxt[i]  = 1'b0;
          pend_nxt[i] = 1'b1;
        end else if (st_r == ST_WAIT && lk_ack && job_r == JOB_COPY && job_idx_r[1:0] == 2'(i)
                     && !pend_r[i]) begin
          cur_nxt[i] = lk_rdata[c.bitpos];
        end
      end
    end
  end

  // link sequencer: pending notifications first, then screen copies, then the refresh scan
  always_comb begin
    ltsb_cfg_s   c;
    logic [1:0]  n;
    logic [15:0] m;
    logic        word_unit;
    c             = cfg_of(32'h0);
    n             = first_set(pend_r);
    m             = 16'h0000;
    word_unit     = 1'b0;
    st_nxt        = st_r;
    job_nxt       = job_r;
    job_idx_nxt   = job_idx_r;
    scan_nxt      = scan_r;
    copy_idx_nxt  = copy_idx_r;
    copy_pend_nxt = copy_pend_r | scr_pulse;
    poll_act_nxt  = poll_act_r | (ctrl_r[CTRL_POLL_EN] && poll_cnt_r >= POLL_CYC - 1);
    lk_req_nxt    = lk_req_r;
    lk_valid_nxt  = lk_valid_r;
    issue_clr     = '0;
    irq_ev        = IRQ_RST;
    lamp_on_nxt   = lamp_on_r;
    ctl_on_nxt    = ctl_on_r;
    if (scr_pulse) copy_idx_nxt = 2'h0;
    case (st_r)
      ST_IDLE: begin
        if (|pend_r) begin
          c         = cfg_of(ntf_cfg_r[n]);
          m         = BIT_ONE << c.bitpos;
          word_unit = !fast_link || c.area == AREA_DATA_MEMORY;
          lk_req_nxt.write = 1'b1;
          lk_req_nxt.area  = c.area;
          lk_req_nxt.word  = c.word;
          if (!word_unit) begin
            lk_req_nxt.wdata = cur_r[n] ? m : 16'h0000;
            lk_req_nxt.wmask = m;
          end else if (rev2 ? c.mode == MODE_MOMENTARY : 1'b1) begin
            lk_req_nxt.wdata = cur_r[n] ? m : 16'h0000;
            lk_req_nxt.wmask = WORD_ALL;
          end else begin
            lk_req_nxt.wdata = (copy_word_r[n] & ~m) | (cur_r[n] ? m : 16'h0000);
            lk_req_nxt.wmask = WORD_ALL;
          end
          issue_clr[n] = 1'b1;
          job_nxt      = JOB_NOTIFY;
          job_idx_nxt  = {1'b0, n};
          lk_valid_nxt = 1'b1;
          st_nxt       = ST_WAIT;
        end else if (copy_pend_r && !scr_pulse) begin
          c = cfg_of(ntf_cfg_r[copy_idx_r]);
          if (item_ok(c)) begin
            lk_req_nxt   = '{write: 1'b0, area: c.area, word: c.word, wdata: 16'h0000, wmask: 16'h0000};
            job_nxt      = JOB_COPY;
            job_idx_nxt  = {1'b0, copy_idx_r};
            lk_valid_nxt = 1'b1;
            st_nxt       = ST_WAIT;
          end
          copy_idx_nxt = copy_idx_r + 2'h1;
          if (copy_idx_r == 2'(NUM_SW - 1)) begin
            copy_pend_nxt    = 1'b0;
            irq_ev[IRQ_COPY] = 1'b1;
          end
        end else if (poll_act_r) begin
          c = (scan_r < 3'(NUM_LAMP)) ? cfg_of(lamp_cfg_r[scan_r[1:0]]) : cfg_of(ctl_cfg_r[scan_r[1:0]]);
          if (item_ok(c)) begin
            lk_req_nxt   = '{write: 1'b0, area: c.area, word: c.word, wdata: 16'h0000, wmask: 16'h0000};
            job_nxt      = JOB_POLL;
            job_idx_nxt  = scan_r;
            lk_valid_nxt = 1'b1;
            st_nxt       = ST_WAIT;
          end
          scan_nxt = scan_r + 3'h1;
          if (scan_r == 3'(NUM_LAMP + NUM_SW - 1)) begin
            poll_act_nxt     = 1'b0;
            irq_ev[IRQ_POLL] = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        if (lk_ack) begin
          lk_valid_nxt = 1'b0;
          st_nxt       = ST_IDLE;
          if (job_r == JOB_NOTIFY) begin
            irq_ev[job_idx_r[1:0]] = 1'b1;
          end else if (job_r == JOB_POLL && job_idx_r < 3'(NUM_LAMP)) begin
            c = cfg_of(lamp_cfg_r[job_idx_r[1:0]]);
            lamp_on_nxt[job_idx_r[1:0]] = lk_rdata[c.bitpos];
          end else if (job_r == JOB_POLL) begin
            c = cfg_of(ctl_cfg_r[job_idx_r[1:0]]);
            ctl_on_nxt[job_idx_r[1:0]] = lk_rdata[c.bitpos];
          end
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // sequencer and switch state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r        <= ST_IDLE;
      job_r       <= JOB_NOTIFY;
      job_idx_r   <= 3'h0;
      scan_r      <= 3'h0;
      copy_idx_r  <= 2'h0;
      copy_pend_r <= 1'b0;
      poll_act_r  <= 1'b0;
      lk_req_r    <= '0;
      lk_valid_r  <= 1'b0;
      cur_r       <= '0;
      pend_r      <= '0;
      ign_r       <= '0;
      lamp_on_r   <= '0;
      ctl_on_r    <= '0;
    end else begin
      st_r        <= st_nxt;
      job_r       <= job_nxt;
      job_idx_r   <= job_idx_nxt;
      scan_r      <= scan_nxt;
      copy_idx_r  <= copy_idx_nxt;
      copy_pend_r <= copy_pend_nxt;
      poll_act_r  <= poll_act_nxt;
      lk_req_r    <= lk_req_nxt;
      lk_valid_r  <= lk_valid_nxt;
      cur_r       <= cur_nxt;
      pend_r      <= pend_nxt;
      ign_r       <= ign_nxt;
      lamp_on_r   <= lamp_on_nxt;
      ctl_on_r    <= ctl_on_nxt;
    end
  end

  // word copies: taken on screen display, then kept in step with what we write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_SW; i++) copy_word_r[i] <= 16'h0000;
    end else if (st_r == ST_WAIT && lk_ack && job_r == JOB_COPY) begin
      copy_word_r[job_idx_r[1:0]] <= lk_rdata;
    end else if (st_r == ST_WAIT && lk_ack && job_r == JOB_NOTIFY) begin
      copy_word_r[job_idx_r[1:0]] <= (copy_word_r[job_idx_r[1:0]] & ~lk_req_r.wmask)
                                     | (lk_req_r.wdata & lk_req_r.wmask);
    end
  end

  // refresh timer; idle while a scan runs so scans never overlap
  always_ff @(posedge aclk) begin
    if (!aresetn) poll_cnt_r <= 32'h00000000;
    else if (!ctrl_r[CTRL_POLL_EN] || poll_act_r || poll_cnt_r >= POLL_CYC - 1) poll_cnt_r <= 32'h00000000;
    else poll_cnt_r <= poll_cnt_r + 32'h00000001;
  end

  // display outputs: attribute chooses steady or flashing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lamp_lit_r   <= '0;
      lamp_flash_r <= '0;
      sw_lit_r     <= '0;
      sw_flash_r   <= '0;
    end else begin
      for (int i = 0; i < NUM_LAMP; i++) begin
        lamp_lit_r[i]   <= lamp_on_r[i] & ~lamp_cfg_r[i][25];
        lamp_flash_r[i] <= lamp_on_r[i] & lamp_cfg_r[i][25];
      end
      for (int i = 0; i < NUM_SW; i++) begin
        sw_lit_r[i]   <= ctl_on_r[i] & ~ctl_cfg_r[i][25];
        sw_flash_r[i] <= ctl_on_r[i] & ctl_cfg_r[i][25];
      end
    end
  end

endmodule

// ### test/ltsb_props.sv
// checker on the engine ports: bus handshakes, link requests, display outputs
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ns
module ltsb_props import ltsb_pkg::*; (
  input wire logic         aclk, aresetn, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire logic         s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, lk_req_valid, lk_ack, irq,
  input wire logic [1:0]   s_axi_bresp,
  input wire logic [31:0]  s_axi_rdata,
  input wire ltsb_lk_req_s lk_req,
  input wire logic [3:0]   lamp_lit, lamp_flash, sw_lit, sw_flash
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_write_closed: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write open");
  a_req_stable: assert property (lk_req_valid && !lk_ack |=> lk_req_valid && $stable(lk_req))
    else $error("link request changed");
  a_req_gap: assert property (lk_ack |=> !lk_req_valid) else $error("no gap after ack");
  a_area_legal: assert property (lk_req_valid |-> lk_req.area < AREA_TIMER) else $error("bad area");
  a_dm_word: assert property (lk_req_valid && lk_req.write && lk_req.area == AREA_DATA_MEMORY
    |-> lk_req.wmask == WORD_ALL) else $error("data memory not word unit");
  a_bit_unit: assert property (lk_req_valid && lk_req.write && lk_req.wmask != WORD_ALL
    |-> $onehot(lk_req.wmask) && (lk_req.wdata & ~lk_req.wmask) == 16'h0) else $error("bad bit write");
  a_show_one: assert property ((lamp_lit & lamp_flash) == 4'h0 && (sw_lit & sw_flash) == 4'h0)
    else $error("steady and flashing together");
  c_notify: cover property (lk_ack && lk_req.write);
  c_read: cover property (lk_ack && !lk_req.write);
  c_irq: cover property ($rose(irq));
endmodule
bind ltsb_engine ltsb_props u_props (.*);

// ### test/ltsb_mem.sv
// controller memory behind the link: masked writes, whole-word reads
// assumes one request at a time, answered after dly waiting cycles
`timescale 1ns/1ns
module ltsb_mem import ltsb_pkg::*; (
  input  wire logic         aclk,
  input  wire ltsb_lk_req_s lk_req,
  input  wire logic         lk_req_valid,
  input  wire logic [3:0]   dly,
  output logic              lk_ack,
  output logic [15:0]       lk_rdata
);
  logic [15:0] mem [logic [18:0]];
  logic [15:0] old;
  logic [18:0] key;
  int          cnt = 0;
  assign key = {lk_req.area, lk_req.word};
  initial {lk_ack, lk_rdata} = '0;
  // one ack pulse per request; read data toggles outside the ack cycle
  always @(posedge aclk) begin
    lk_ack <= 1'b0;
    lk_rdata <= ~lk_rdata;
    if (lk_req_valid && !lk_ack) begin
      if (cnt < dly) cnt <= cnt + 1;
      else begin
        old = mem.exists(key) ? mem[key] : 16'h0;
        cnt <= 0;
        lk_ack <= 1'b1;
        lk_rdata <= old;
        if (lk_req.write) mem[key] = (old & ~lk_req.wmask) | (lk_req.wdata & lk_req.wmask);
      end
    end
  end
endmodule

// ### test/ltsb_engine_tb_top.sv
// bench: registers, lamp refresh, touch notify vs memory model
// assumes ltsb_mem on the link and ltsb_props bound to the engine
`timescale 1ns/1ns
module ltsb_engine_tb_top import ltsb_pkg::*;;
  logic         aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, irq;
  logic         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, lk_req_valid, lk_ack;
  logic [1:0]   s_axi_bresp, s_axi_rresp, rr;
  logic [2:0]   a;
  logic [3:0]   s_axi_wstrb, touch_press, lamp_lit, lamp_flash, sw_lit, sw_flash, dly, b;
  logic [7:0]   s_axi_awaddr, s_axi_araddr;
  logic [15:0]  lk_rdata, r, w;
  logic [31:0]  s_axi_wdata, s_axi_rdata, rv, seed;
  ltsb_lk_req_s lk_req;
  int           n_mismatch = 0, checks_done = 0, md;
  logic [7:0]   regs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h30};
  ltsb_engine #(.POLL_CYC(50)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .touch_press, .lk_req, .lk_req_valid, .lk_ack, .lk_rdata, .lamp_lit, .lamp_flash, .sw_lit, .sw_flash, .irq);
  ltsb_mem u_mem (.aclk, .lk_req, .lk_req_valid, .dly, .lk_ack, .lk_rdata);
  // stimulus and expected word
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] cfg(input logic fl, input logic [1:0] m, input logic [2:0] ar,
                                      input logic [3:0] bt, input logic [15:0] wd);
    return {5'h0, 1'b1, fl, m, ar, bt, wd};
  endfunction
  function automatic logic [15:0] exp_w(input int m, input logic wu, input logic [15:0] o,
                                        input logic [3:0] bt, input logic p);
    logic [15:0] k;
    k = 16'h1 << bt;
    case (m)
      0: return wu ? (p ? k : 16'h0) : (p ? o | k : o & ~k);
      1: return o ^ k;
      2: return o | k;
      default: return o & ~k;
    endcase
  endfunction
  // bus master: release each channel once taken
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge aclk);
    s_axi_araddr <= ad;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    {rr, rv} = {s_axi_rresp, s_axi_rdata};
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    end_sim;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, touch_press, dly} = '0;
    s_axi_wstrb = 4'hF;
    seed = 32'hC996;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, ignored writes, unmapped, cfg width
    wr(REG_DISP, '1);
    foreach (regs[i]) begin
      rd(regs[i]);
      chk({rr, rv}, {RESP_OKAY, 32'h0});
    end
    rd(8'h40);
    chk({rr, rv}, {RESP_SLVERR, 32'h0});
    wr(8'h24, '1);
    rd(8'h24);
    chk(rv, CFG_MASK);
    wr(8'h24, 32'h0);
    wr(REG_IRQ_MASK, 32'h1);
    // lamp0 steady, lamp1 flashing, switch0 lit
    wr(8'h10, cfg(1'b0, 2'd0, 3'd2, 4'd3, 16'd7));
    wr(8'h14, cfg(1'b1, 2'd0, 3'd2, 4'd9, 16'd7));
    wr(8'h30, cfg(1'b0, 2'd0, 3'd2, 4'd3, 16'd7));
    wr(REG_CTRL, 32'h6);
    for (int k = 0; k < 2; k++) begin
      u_mem.mem[{3'd2, 16'd7}] = k ? 16'h0 : 16'h0208;
      repeat (150) @(posedge aclk);
      chk({lamp_flash, lamp_lit, sw_flash, sw_lit}, k ? 16'h0 : 16'h2101);
    end
    // all modes per link kind; md 4: old revision
    for (int m = 0; m < 15; m++) begin
      seed = lfsr(seed);
      md = m / 3;
      {dly, b, w, r} = {1'b0, seed[30:28], seed[19:16], 8'h0, seed[27:20], seed[15:0]};
      a = (m % 3 == 1) ? 3'd0 : 3'd1;
      u_mem.mem[{a, w}] = r;
      wr(8'h20, cfg(1'b0, md == 4 ? 2'd1 : md[1:0], a, b, w));
      wr(REG_CTRL, {28'h0, 2'h3, md != 4, m % 3 != 0});
      repeat (60) @(posedge aclk);
      for (int p = 1; p >= 0; p--) begin
        touch_press[0] <= p[0];
        repeat (60) @(posedge aclk);
        chk(u_mem.mem[{a, w}], exp_w(md == 4 ? 0 : md, m % 3 != 2, r, b, p[0]));
      end
      chk(irq, 1'b1);
      rd(REG_IRQ_STAT);
      chk(rv[0], 1'b1);
      repeat (3) @(posedge aclk);
      chk(irq, 1'b0);
    end
    // screen change with momentary held
    u_mem.mem[{3'd0, 16'd9}] = 16'hFFFF;
    wr(8'h20, cfg(1'b0, 2'd0, 3'd0, 4'd5, 16'd9));
    wr(REG_CTRL, 32'h6);
    touch_press[0] <= 1'b1;
    repeat (60) @(posedge aclk);
    chk(u_mem.mem[{3'd0, 16'd9}], 16'h0020);
    wr(REG_CTRL, 32'hE);
    repeat (60) @(posedge aclk);
    chk(u_mem.mem[{3'd0, 16'd9}], 16'h0);
    touch_press[0] <= 1'b0;
    end_sim;
  end
endmodule
